/* atasrb_cfg.svh */
// Offsets, field positions and reset values of the shadow task-file bank
`ifndef ATASRB_CFG_SVH
`define ATASRB_CFG_SVH

// ------------------------------------------------------------
// Register addresses as seen in the shadow frames
// ------------------------------------------------------------
`define ATASRB_ADDR_DATA 10'h1F0
`define ATASRB_ADDR_ERR_FEAT 10'h1F1
`define ATASRB_ADDR_COUNT 10'h1F2
`define ATASRB_ADDR_ADDR0 10'h1F3
`define ATASRB_ADDR_ADDR1 10'h1F4
`define ATASRB_ADDR_ADDR2 10'h1F5
`define ATASRB_ADDR_DEVICE 10'h1F6
`define ATASRB_ADDR_STAT_CMD 10'h1F7
`define ATASRB_ADDR_ALT_CTRL 10'h3F6

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define ATASRB_CTL_HOB 7
`define ATASRB_CTL_SOFT_RESET_BIT 2
`define ATASRB_CTL_INTERRUPT_MASK_BIT 1
`define ATASRB_DEV_LBA 6
`define ATASRB_ERR_ABORTED_FLAG 2
`define ATASRB_ST_BSY 7
`define ATASRB_ST_DRIVE_CAN_ACCEPT_FLAG 6
`define ATASRB_ST_DRQ 3
`define ATASRB_ST_ERR 0

// ------------------------------------------------------------
// Reset values, and the 9-bit count given for a zero count byte
// ------------------------------------------------------------
`define ATASRB_RST_BYTE 8'h00
`define ATASRB_RST_COUNT 8'h01
`define ATASRB_RST_ADDR0 8'h01
`define ATASRB_RST_DIAG 8'h01
`define ATASRB_RST_DEVICE 8'h00
`define ATASRB_RST_WORD 16'h0000
`define ATASRB_CNT28_ZERO 9'h100

`endif

/* atasrb_pkg.sv */
// Types of the shadow task-file bank
package atasrb_pkg;

  typedef struct packed {
    logic [7:0] prev;
    logic [7:0] cur;
  } atasrb_pair_t;

  typedef struct packed {
    logic done;
    logic ok;
    logic diag;
    logic abort;
    logic [7:0] err_bits;
    logic [7:0] err_used;
    logic [15:0] remaining;
    logic [47:0] addr;
    logic [3:0] head;
  } atasrb_done_t;

  typedef struct packed {
    logic [15:0] data;
    logic [7:0] err;
    atasrb_pair_t feat;
    atasrb_pair_t count;
    atasrb_pair_t addr0;
    atasrb_pair_t addr1;
    atasrb_pair_t addr2;
    logic [7:0] device;
    logic [7:0] cmd;
    logic high_order_select;
    logic soft_reset_bit;
    logic interrupt_mask_bit;
    logic busy_flag;
    logic err_flag;
    logic drive_can_accept_flag_frozen;
    logic drive_can_accept_flag_hold;
    logic irq_pend;
    logic cmd_start;
    logic data_push;
    logic data_pop;
    logic [15:0] rdata;
    logic rvalid;
  } atasrb_state_t;

endpackage

/* atasrb_bank.sv */
// Shadow task-file register bank of the drive, loaded through link frames
`timescale 1ns/1ps
`include "atasrb_cfg.svh"

module atasrb_bank
  import atasrb_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // Shadow access from the link layer
  input wire logic tf_wr_i,
  input wire logic tf_rd_i,
  input wire logic [9:0] tf_addr_i,
  input wire logic [15:0] tf_wdata_i,
  output logic [15:0] tf_rdata_o,
  output logic tf_rvalid_o,
  // Drive buffer side of the data register
  input wire logic buf_load_i,
  input wire logic [15:0] buf_data_i,
  output logic data_push_o,
  output logic data_pop_o,
  output logic [15:0] data_word_o,
  // Drive core
  input wire logic drive_ready_i,
  input wire logic drq_i,
  input wire logic drive_sel_i,
  input wire atasrb_done_t done_i,
  output logic cmd_start_o,
  output logic [7:0] cmd_code_o,
  output logic [15:0] feature_o,
  output logic [8:0] count28_o,
  output logic [15:0] count48_o,
  output logic [47:0] lba48_o,
  output logic [27:0] lba28_o,
  output logic lba_mode_o,
  output logic busy_o,
  output logic soft_reset_o,
  // Interrupt pin as two signals
  output logic intrq_o,
  output logic intrq_oe_o
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] pair_read(input atasrb_pair_t p, input logic high_order_select);
    pair_read = high_order_select ? p.prev : p.cur;
  endfunction

  function automatic atasrb_pair_t pair_write(input atasrb_pair_t p, input logic [7:0] b);
    pair_write.prev = p.cur;
    pair_write.cur = b;
  endfunction

  function automatic atasrb_state_t reset_state();
    atasrb_state_t s;
    s = '0;
    s.data = `ATASRB_RST_WORD;
    s.err = `ATASRB_RST_DIAG;
    s.feat = '{prev: `ATASRB_RST_BYTE, cur: `ATASRB_RST_BYTE};
    s.count = '{prev: `ATASRB_RST_BYTE, cur: `ATASRB_RST_COUNT};
    s.addr0 = '{prev: `ATASRB_RST_BYTE, cur: `ATASRB_RST_ADDR0};
    s.addr1 = '{prev: `ATASRB_RST_BYTE, cur: `ATASRB_RST_BYTE};
    s.addr2 = '{prev: `ATASRB_RST_BYTE, cur: `ATASRB_RST_BYTE};
    s.device = `ATASRB_RST_DEVICE;
    s.cmd = `ATASRB_RST_BYTE;
    reset_state = s;
  endfunction

  atasrb_state_t st;
  atasrb_state_t next_st;
  logic [7:0] status_byte;
  logic drive_can_accept_flag_now;

  // ------------------------------------------------------------
  // Status composition
  // ------------------------------------------------------------
  // Ready stays frozen after an error until the host reads status
  assign drive_can_accept_flag_now = st.drive_can_accept_flag_frozen ? st.drive_can_accept_flag_hold : drive_ready_i;

  always_comb begin
    status_byte = 8'h00;
    status_byte[`ATASRB_ST_BSY] = st.busy_flag;
    status_byte[`ATASRB_ST_DRIVE_CAN_ACCEPT_FLAG] = drive_can_accept_flag_now;
    status_byte[`ATASRB_ST_DRQ] = drq_i;
    status_byte[`ATASRB_ST_ERR] = st.err_flag;
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.cmd_start = 1'b0;
    next_st.data_push = 1'b0;
    next_st.data_pop = 1'b0;
    next_st.rvalid = 1'b0;

    // Drive buffer refills the data register
    if (buf_load_i) begin
      next_st.data = buf_data_i;
    end

    // Completion report from the drive core
    if (done_i.done) begin
      next_st.busy_flag = 1'b0;
      next_st.irq_pend = 1'b1;
      next_st.err_flag = ~done_i.ok;
      if (done_i.diag) begin
        next_st.err = done_i.err_bits;
      end else begin
        next_st.err = done_i.err_bits & done_i.err_used;
        next_st.err[`ATASRB_ERR_ABORTED_FLAG] = done_i.abort;
      end
      if (!done_i.ok) begin
        next_st.drive_can_accept_flag_frozen = 1'b1;
        next_st.drive_can_accept_flag_hold = drive_ready_i;
      end
      next_st.count.cur = done_i.ok ? 8'h00 : done_i.remaining[7:0];
      next_st.count.prev = done_i.ok ? 8'h00 : done_i.remaining[15:8];
      next_st.addr0 = '{prev: done_i.addr[31:24], cur: done_i.addr[7:0]};
      next_st.addr1 = '{prev: done_i.addr[39:32], cur: done_i.addr[15:8]};
      next_st.addr2 = '{prev: done_i.addr[47:40], cur: done_i.addr[23:16]};
      next_st.device[3:0] = done_i.head;
    end

    // Host reads: answer registered one cycle later
    if (tf_rd_i) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = 16'h0000;
      if (tf_addr_i == `ATASRB_ADDR_ALT_CTRL) begin
        next_st.rdata[7:0] = status_byte;
      end else if (st.busy_flag && tf_addr_i[9:3] == `ATASRB_ADDR_DATA >> 3) begin
        next_st.rdata[7:0] = status_byte;
      end else begin
        unique case (tf_addr_i)
          `ATASRB_ADDR_DATA: begin
            next_st.rdata = st.data;
            next_st.data_pop = 1'b1;
          end
          `ATASRB_ADDR_ERR_FEAT: next_st.rdata[7:0] = st.err;
          `ATASRB_ADDR_COUNT: next_st.rdata[7:0] = pair_read(st.count, st.high_order_select);
          `ATASRB_ADDR_ADDR0: next_st.rdata[7:0] = pair_read(st.addr0, st.high_order_select);
          `ATASRB_ADDR_ADDR1: next_st.rdata[7:0] = pair_read(st.addr1, st.high_order_select);
          `ATASRB_ADDR_ADDR2: next_st.rdata[7:0] = pair_read(st.addr2, st.high_order_select);
          `ATASRB_ADDR_DEVICE: next_st.rdata[7:0] = st.device;
          `ATASRB_ADDR_STAT_CMD: begin
            next_st.rdata[7:0] = status_byte;
            // Completion in the same cycle keeps its interrupt
            if (!done_i.done) begin
              next_st.irq_pend = 1'b0;
              next_st.drive_can_accept_flag_frozen = 1'b0;
            end
          end
          default: next_st.rdata = 16'h0000;
        endcase
      end
    end

    // Host writes
    if (tf_wr_i) begin
      unique case (tf_addr_i)
        `ATASRB_ADDR_DATA: begin
          next_st.data = tf_wdata_i;
          next_st.data_push = 1'b1;
        end
        `ATASRB_ADDR_ERR_FEAT: next_st.feat = pair_write(st.feat, tf_wdata_i[7:0]);
        `ATASRB_ADDR_COUNT: next_st.count = pair_write(st.count, tf_wdata_i[7:0]);
        `ATASRB_ADDR_ADDR0: next_st.addr0 = pair_write(st.addr0, tf_wdata_i[7:0]);
        `ATASRB_ADDR_ADDR1: next_st.addr1 = pair_write(st.addr1, tf_wdata_i[7:0]);
        `ATASRB_ADDR_ADDR2: next_st.addr2 = pair_write(st.addr2, tf_wdata_i[7:0]);
        `ATASRB_ADDR_DEVICE: next_st.device = tf_wdata_i[7:0];
        `ATASRB_ADDR_STAT_CMD: begin
          // Launch at once; parameters must already be in place
          next_st.cmd = tf_wdata_i[7:0];
          next_st.cmd_start = 1'b1;
          next_st.busy_flag = 1'b1;
          next_st.err_flag = 1'b0;
          // A completion in the same cycle keeps its interrupt
          if (!done_i.done) begin
            next_st.irq_pend = 1'b0;
          end
        end
        `ATASRB_ADDR_ALT_CTRL: begin
          // Only three bits are kept; the rest are reserved
          next_st.high_order_select = tf_wdata_i[`ATASRB_CTL_HOB];
          next_st.soft_reset_bit = tf_wdata_i[`ATASRB_CTL_SOFT_RESET_BIT];
          next_st.interrupt_mask_bit = tf_wdata_i[`ATASRB_CTL_INTERRUPT_MASK_BIT];
        end
        default: next_st.cmd_start = 1'b0;
      endcase
    end

    // Held in reset while the soft reset bit stays set
    if (st.soft_reset_bit) begin
      next_st = reset_state();
      next_st.soft_reset_bit = tf_wr_i && tf_addr_i == `ATASRB_ADDR_ALT_CTRL ?
                     tf_wdata_i[`ATASRB_CTL_SOFT_RESET_BIT] : 1'b1;
      next_st.high_order_select = st.high_order_select;
      next_st.interrupt_mask_bit = st.interrupt_mask_bit;
      if (tf_wr_i && tf_addr_i == `ATASRB_ADDR_ALT_CTRL) begin
        next_st.high_order_select = tf_wdata_i[`ATASRB_CTL_HOB];
        next_st.interrupt_mask_bit = tf_wdata_i[`ATASRB_CTL_INTERRUPT_MASK_BIT];
      end
      next_st.rdata = tf_rd_i ? {8'h00, 8'h80} : 16'h0000;
      next_st.rvalid = tf_rd_i;
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      st <= reset_state();
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign tf_rdata_o = st.rdata;
  assign tf_rvalid_o = st.rvalid;
  assign data_push_o = st.data_push;
  assign data_pop_o = st.data_pop;
  assign data_word_o = st.data;
  assign cmd_start_o = st.cmd_start;
  assign cmd_code_o = st.cmd;
  assign feature_o = {st.feat.prev, st.feat.cur};
  assign count28_o = st.count.cur == 8'h00 ? `ATASRB_CNT28_ZERO : {1'b0, st.count.cur};
  assign count48_o = {st.count.prev, st.count.cur};
  assign lba48_o = {st.addr2.prev, st.addr1.prev, st.addr0.prev,
                    st.addr2.cur, st.addr1.cur, st.addr0.cur};
  assign lba28_o = {st.device[3:0], st.addr2.cur, st.addr1.cur, st.addr0.cur};
  assign lba_mode_o = st.device[`ATASRB_DEV_LBA];
  assign busy_o = st.busy_flag;
  assign soft_reset_o = st.soft_reset_bit;
  assign intrq_o = st.irq_pend;
  assign intrq_oe_o = ~st.interrupt_mask_bit & drive_sel_i;

endmodule // atasrb_bank

/* atasrb_assertions.sv */
// Port checker of the shadow task-file bank
`timescale 1ns/1ps
`include "atasrb_cfg.svh"
module atasrb_chk
  import atasrb_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic tf_wr_i,
  input wire logic tf_rd_i,
  input wire logic [9:0] tf_addr_i,
  input wire logic [15:0] tf_wdata_i,
  input wire logic [15:0] tf_rdata_o,
  input wire logic tf_rvalid_o,
  input wire logic drive_sel_i,
  input wire atasrb_done_t done_i,
  input wire logic cmd_start_o,
  input wire logic [7:0] cmd_code_o,
  input wire logic [8:0] count28_o,
  input wire logic [15:0] count48_o,
  input wire logic [47:0] lba48_o,
  input wire logic [27:0] lba28_o,
  input wire logic busy_o,
  input wire logic soft_reset_o,
  input wire logic intrq_o,
  input wire logic intrq_oe_o
);
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  property p_rv; tf_rd_i |=> tf_rvalid_o; endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  property p_start;
    tf_wr_i && tf_addr_i == `ATASRB_ADDR_STAT_CMD && !busy_o && !soft_reset_o |=>
      cmd_start_o && busy_o && {8'h00, cmd_code_o} == ($past(tf_wdata_i) & 16'h00FF);
  endproperty
  a_start: assert property (p_start) else $error("command not launched");
  property p_pulse; cmd_start_o |=> !cmd_start_o; endproperty
  a_pulse: assert property (p_pulse) else $error("launch pulse too long");
  property p_done; done_i.done && busy_o && !soft_reset_o && !tf_wr_i |=> !busy_o && intrq_o;
  endproperty
  a_done: assert property (p_done) else $error("completion not posted");
  property p_bsyrd; busy_o && tf_rd_i && tf_addr_i[9:3] == 7'h3E |=> tf_rdata_o[7];
  endproperty
  a_bsyrd: assert property (p_bsyrd) else $error("busy read not status");
  property p_ack;
    tf_rd_i && tf_addr_i == `ATASRB_ADDR_STAT_CMD && intrq_o && !done_i.done |=> !intrq_o;
  endproperty
  a_ack: assert property (p_ack) else $error("status read kept irq");
  property p_alt;
    tf_rd_i && tf_addr_i == `ATASRB_ADDR_ALT_CTRL && intrq_o && !tf_wr_i && !soft_reset_o
      |=> intrq_o;
  endproperty
  a_alt: assert property (p_alt) else $error("alt read cleared irq");
  property p_oe; !drive_sel_i |-> !intrq_oe_o; endproperty
  a_oe: assert property (p_oe) else $error("irq driven unselected");
  property p_c28;
    count28_o == ((count48_o[7:0] == 8'h00) ? 9'h100 : {1'b0, count48_o[7:0]});
  endproperty
  a_c28: assert property (p_c28) else $error("short count wrong");
  // Old current byte must survive in the previous copy
  property p_lba;
    tf_wr_i && tf_addr_i == `ATASRB_ADDR_ADDR0 && !soft_reset_o |=>
      lba28_o[7:0] == $past(tf_wdata_i[7:0]) && lba48_o[31:24] == $past(lba48_o[7:0]);
  endproperty
  a_lba: assert property (p_lba) else $error("pair write lost a byte");
endmodule // atasrb_chk

bind atasrb_bank atasrb_chk u_chk (.*);

/* atasrb_host.sv */
// Host controller model issuing shadow register frames
`timescale 1ns/1ps
module atasrb_host (
  input wire logic clk_sys_i,
  input wire logic [15:0] rdata_i,
  input wire logic rvalid_i,
  output logic wr_o,
  output logic rd_o,
  output logic [9:0] addr_o,
  output logic [15:0] wdata_o
);
  // ----------------------------------------
  // Frame accesses, the only way in
  // ----------------------------------------
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 10'h000;
    wdata_o = 16'h0000;
  end
  // Released lines show inverted values so stale data never matches
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_sys_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
    #1;
  endtask
  task automatic rd(input logic [9:0] a, output logic [15:0] q, output logic v);
    @(posedge clk_sys_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_sys_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    q = rdata_i;
    v = rvalid_i;
  endtask
endmodule // atasrb_host

/* test_ata_shadow_task_file.sv */
// Self-checking bench of the shadow task-file bank
`timescale 1ns/1ps
`include "atasrb_cfg.svh"
module test_ata_shadow_task_file import atasrb_pkg::*;;
  logic clk_sys_i, rstn_i, tf_wr_i, tf_rd_i, tf_rvalid_o, buf_load_i, data_push_o, data_pop_o;
  logic drive_ready_i, drq_i, drive_sel_i, cmd_start_o, lba_mode_o, busy_o, soft_reset_o;
  logic intrq_o, intrq_oe_o;
  logic [9:0] tf_addr_i;
  logic [15:0] tf_wdata_i, tf_rdata_o, buf_data_i, data_word_o, feature_o, count48_o, w, rem;
  logic [7:0] cmd_code_o, a, b, code;
  logic [7:0] pv[4], cv[4];
  logic [8:0] count28_o;
  logic [47:0] lba48_o, ad;
  logic [27:0] lba28_o;
  atasrb_done_t done_i;
  int n_mismatch = 0, check_count = 0, cyc = 0;
  atasrb_host host (
    .clk_sys_i(clk_sys_i),
    .rdata_i(tf_rdata_o),
    .rvalid_i(tf_rvalid_o),
    .wr_o(tf_wr_i),
    .rd_o(tf_rd_i),
    .addr_o(tf_addr_i),
    .wdata_o(tf_wdata_i)
  );
  atasrb_bank uut (.*);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [9:0] ra, input logic [15:0] e);
    logic [15:0] q;
    logic v;
    host.rd(ra, q, v);
    chk(v, 1'b1);
    chk(q, e);
  endtask
  task automatic complete(input atasrb_done_t d);
    @(posedge clk_sys_i);
    done_i <= d;
    @(posedge clk_sys_i);
    done_i <= '0;
    #1;
  endtask
  function automatic logic [8:0] cnt28(input logic [7:0] v);
    return (v == 8'h00) ? 9'h100 : {1'b0, v};
  endfunction
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // Whole run needs under two hundred cycles
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      stop_test();
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(32));
    rstn_i = 1'b0;
    buf_load_i = 1'b0;
    buf_data_i = 16'h0000;
    drive_ready_i = 1'b1;
    drq_i = 1'b0;
    drive_sel_i = 1'b1;
    done_i = '0;
    repeat (8) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    rdc(`ATASRB_ADDR_ERR_FEAT, 16'h0001);
    rdc(`ATASRB_ADDR_COUNT, 16'h0001);
    rdc(`ATASRB_ADDR_STAT_CMD, 16'h0040);
    rdc(10'h200, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      pv[k] = 8'($urandom);
      cv[k] = (k == 0) ? 8'h00 : 8'($urandom);
      host.wr(`ATASRB_ADDR_COUNT + 10'(k), {8'h00, pv[k]});
      host.wr(`ATASRB_ADDR_COUNT + 10'(k), {8'h00, cv[k]});
      rdc(`ATASRB_ADDR_COUNT + 10'(k), {8'h00, cv[k]});
      host.wr(`ATASRB_ADDR_ALT_CTRL, 16'h0080);
      rdc(`ATASRB_ADDR_COUNT + 10'(k), {8'h00, pv[k]});
      host.wr(`ATASRB_ADDR_ALT_CTRL, 16'h0000);
    end
    chk(count48_o, {pv[0], cv[0]});
    chk(count28_o, cnt28(cv[0]));
    chk(lba48_o, {pv[3], pv[2], pv[1], cv[3], cv[2], cv[1]});
    a = 8'($urandom);
    b = 8'($urandom);
    host.wr(`ATASRB_ADDR_ERR_FEAT, {8'h00, a});
    host.wr(`ATASRB_ADDR_ERR_FEAT, {8'h00, b});
    chk(feature_o, {a, b});
    rdc(`ATASRB_ADDR_ERR_FEAT, 16'h0001);
    host.wr(`ATASRB_ADDR_DEVICE, 16'h004A);
    chk(lba_mode_o, 1'b1);
    chk(lba28_o, {4'hA, cv[3], cv[2], cv[1]});
    w = 16'($urandom);
    host.wr(`ATASRB_ADDR_DATA, w);
    chk({data_push_o, data_word_o}, {1'b1, w});
    @(posedge clk_sys_i);
    buf_load_i <= 1'b1;
    buf_data_i <= ~w;
    @(posedge clk_sys_i);
    buf_load_i <= 1'b0;
    rdc(`ATASRB_ADDR_DATA, ~w);
    chk(data_pop_o, 1'b1);
    code = 8'($urandom);
    rem = 16'($urandom);
    ad = {16'($urandom), 32'($urandom)};
    host.wr(`ATASRB_ADDR_STAT_CMD, {8'h00, code});
    chk({busy_o, cmd_start_o, cmd_code_o}, {2'b11, code});
    rdc(`ATASRB_ADDR_ADDR1, 16'h00C0);
    complete('{done: 1'b1, ok: 1'b0, diag: 1'b0, abort: 1'b1, err_bits: a, err_used: b,
      remaining: rem, addr: ad, head: 4'h5});
    rdc(`ATASRB_ADDR_ERR_FEAT, {8'h00, (a & b & 8'hFB) | 8'h04});
    rdc(`ATASRB_ADDR_COUNT, {8'h00, rem[7:0]});
    rdc(`ATASRB_ADDR_ADDR1, {8'h00, ad[15:8]});
    rdc(`ATASRB_ADDR_ADDR2, {8'h00, ad[23:16]});
    rdc(`ATASRB_ADDR_ALT_CTRL, 16'h0041);
    chk(intrq_o, 1'b1);
    rdc(`ATASRB_ADDR_STAT_CMD, 16'h0041);
    chk(intrq_o, 1'b0);
    host.wr(`ATASRB_ADDR_ALT_CTRL, 16'h0080);
    rdc(`ATASRB_ADDR_COUNT, {8'h00, rem[15:8]});
    rdc(`ATASRB_ADDR_ADDR2, {8'h00, ad[47:40]});
    host.wr(`ATASRB_ADDR_ALT_CTRL, 16'h0000);
    host.wr(`ATASRB_ADDR_STAT_CMD, {8'h00, code});
    complete('{done: 1'b1, ok: 1'b1, diag: 1'b1, abort: 1'b0, err_bits: a, err_used: 8'h00,
      remaining: rem, addr: ad, head: 4'h5});
    rdc(`ATASRB_ADDR_ERR_FEAT, {8'h00, a});
    rdc(`ATASRB_ADDR_COUNT, 16'h0000);
    chk(intrq_oe_o, 1'b1);
    host.wr(`ATASRB_ADDR_ALT_CTRL, 16'h007A);
    chk({intrq_oe_o, soft_reset_o}, 2'b00);
    host.wr(`ATASRB_ADDR_ALT_CTRL, 16'h0000);
    @(posedge clk_sys_i);
    drive_sel_i <= 1'b0;
    #1;
    chk(intrq_oe_o, 1'b0);
    @(posedge clk_sys_i);
    drive_sel_i <= 1'b1;
    host.wr(`ATASRB_ADDR_COUNT, 16'h0055);
    host.wr(`ATASRB_ADDR_ALT_CTRL, 16'h0004);
    chk(soft_reset_o, 1'b1);
    rdc(`ATASRB_ADDR_STAT_CMD, 16'h0080);
    host.wr(`ATASRB_ADDR_ALT_CTRL, 16'h0000);
    rdc(`ATASRB_ADDR_COUNT, 16'h0001);
    @(posedge clk_sys_i);
    drq_i <= 1'b1;
    rdc(`ATASRB_ADDR_ALT_CTRL, 16'h0048);
    // Hardware reset in mid-command must bring back power-on values
    host.wr(`ATASRB_ADDR_COUNT, 16'h0077);
    host.wr(`ATASRB_ADDR_STAT_CMD, {8'h00, code});
    @(posedge clk_sys_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    #1;
    chk({busy_o, intrq_o, soft_reset_o, count48_o}, 19'h00001);
    rdc(`ATASRB_ADDR_ERR_FEAT, 16'h0001);
    rdc(`ATASRB_ADDR_STAT_CMD, 16'h0048);
    stop_test();
  end
endmodule // test_ata_shadow_task_file
